// *** hw/xca_pkg.sv ***
package xca_pkg;

// ----------------------------------------
// register map
// ----------------------------------------
localparam logic [11:0] XCA_CFG_ADDR = 12'h148;
localparam logic [31:0] XCA_CFG_RESET = 32'h0000_0000;
localparam logic [31:0] XCA_RDONLY_ZERO = 32'h0000_0000;

// ----------------------------------------
// field positions
// ----------------------------------------
localparam int XCA_CYC0_LSB = 0;
localparam int XCA_CYC1_LSB = 3;
localparam int XCA_CYC2_LSB = 6;
localparam int XCA_CYCN_LSB = 9;
localparam int XCA_DIV_LSB = 12;
localparam int XCA_SPARE_LSB = 5;
localparam int XCA_MODE_BIT = 23;
localparam int XCA_IRQLVL_LSB = 24;
localparam int XCA_CSLVL_LSB = 28;
localparam int XCA_PCILVL_BIT = 31;
localparam int XCA_PRIO_SELF_BIT = 4;

// ----------------------------------------
// writable register mask
// ----------------------------------------
localparam logic [31:0] XCA_RW_MASK = 32'hff00_3fff;

typedef enum logic [0:0] {
    XCA_MODE_ARB = 1'b0,
    XCA_MODE_XBUS = 1'b1
} xca_mode_e;

endpackage

// *** hw/xca_div.sv ***
`timescale 1ns/1ps
`default_nettype none
module xca_div
    import xca_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic enable,
    input wire logic [1:0] div_sel,
    output logic tick
);
    typedef struct packed {
        logic [1:0] cnt;
        logic tick;
    } xca_div_s;

    xca_div_s st_q, st_d;

    // ----------------------------------------
    // strobe clock divider, divisor = sel + 1
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (!enable) begin
            st_d.cnt = 2'h0;
        end else if (st_q.cnt >= div_sel) begin
            st_d.cnt = 2'h0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 2'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;
endmodule // xca_div
`default_nettype wire

// *** hw/xca_cfg.sv ***
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module xca_cfg
    import xca_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic mode_strap_pin,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    output logic xbus_mode,
    output logic [2:0] cyc_len_cs0,
    output logic [2:0] cyc_len_cs1,
    output logic [2:0] cyc_len_cs2,
    output logic [2:0] cyc_len_none,
    output logic [1:0] strobe_div_sel,
    output logic strobe_tick,
    output logic [3:0] irq_in_active_high,
    output logic [2:0] cs_active_high,
    output logic pci_irq_active_high,
    output logic prio_self_high,
    output logic [3:0] prio_req_high
);
    typedef struct packed {
        logic strap_done;
        xca_mode_e mode;
        logic [31:0] cfg;
        logic [31:0] rdata;
        logic err;
    } xca_cfg_s;

    xca_cfg_s st_q, st_d;
    logic hit;
    logic access;

    // ----------------------------------------
    // register read view
    // ----------------------------------------
    function automatic logic [31:0] read_view(input logic [31:0] cfg,
                                              input xca_mode_e mode);
        logic [31:0] v;
        v = cfg & XCA_RW_MASK;
        v[XCA_MODE_BIT] = (mode == XCA_MODE_ARB);
        return v;
    endfunction

    assign hit = (paddr[11:2] == XCA_CFG_ADDR[11:2]);
    assign access = psel && penable;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        if (!st_q.strap_done) begin
            st_d.strap_done = 1'b1;
            st_d.mode = xca_mode_e'(mode_strap_pin);
        end
        if (access && pwrite && hit) begin
            st_d.cfg = pwdata & XCA_RW_MASK;
        end
        if (psel && !penable) begin
            st_d.err = !hit;
            if (hit) begin
                st_d.rdata = read_view(st_q.cfg, st_q.mode);
            end else begin
                st_d.rdata = XCA_RDONLY_ZERO;
            end
        end
    end

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q.strap_done <= 1'b0;
            st_q.mode <= XCA_MODE_XBUS;
            st_q.cfg <= XCA_CFG_RESET;
            st_q.rdata <= 32'h0000_0000;
            st_q.err <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // apb answer
    // ----------------------------------------
    assign pready = 1'b1;
    assign pslverr = access && st_q.err;
    assign prdata = st_q.rdata;

    // ----------------------------------------
    // field outputs
    // ----------------------------------------
    always_comb begin
        xbus_mode = (st_q.mode == XCA_MODE_XBUS);
        cyc_len_cs0 = xbus_mode ? st_q.cfg[XCA_CYC0_LSB +: 3] : 3'h0;
        cyc_len_cs1 = xbus_mode ? st_q.cfg[XCA_CYC1_LSB +: 3] : 3'h0;
        cyc_len_cs2 = xbus_mode ? st_q.cfg[XCA_CYC2_LSB +: 3] : 3'h0;
        cyc_len_none = xbus_mode ? st_q.cfg[XCA_CYCN_LSB +: 3] : 3'h0;
        strobe_div_sel = xbus_mode ? st_q.cfg[XCA_DIV_LSB +: 2] : 2'h0;
        irq_in_active_high = st_q.cfg[XCA_IRQLVL_LSB +: 4];
        cs_active_high = st_q.cfg[XCA_CSLVL_LSB +: 3];
        pci_irq_active_high = st_q.cfg[XCA_PCILVL_BIT];
        prio_self_high = !xbus_mode && st_q.cfg[XCA_PRIO_SELF_BIT];
        prio_req_high = xbus_mode ? 4'h0 : st_q.cfg[3:0];
    end

    xca_div u_div (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .enable(xbus_mode),
        .div_sel(strobe_div_sel),
        .tick(strobe_tick)
    );
endmodule // xca_cfg
`default_nettype wire

// *** tb/xca_cfg_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module xca_cfg_chk
    import xca_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic xbus_mode,
    input wire logic [2:0] cyc_len_cs0,
    input wire logic [1:0] strobe_div_sel,
    input wire logic strobe_tick,
    input wire logic [3:0] irq_in_active_high,
    input wire logic [3:0] prio_req_high
);
    // ----
    // access checks
    // ----
    wire logic hit = clk_en && psel && penable &&
        paddr[11:2] == XCA_CFG_ADDR[11:2];
    wire logic wr = hit && pwrite;
    wire logic rd = hit && !pwrite;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_back;
        wr ##3 rd;
    endsequence
    a_irq_level: assert property (
        wr |=> irq_in_active_high == $past(pwdata[27:24])) else $error("irq");
    a_cyc_len: assert property (
        wr |=> cyc_len_cs0 == (xbus_mode ? $past(pwdata[2:0]) : 3'h0))
        else $error("cyc");
    a_div_sel: assert property (
        wr |=> strobe_div_sel == (xbus_mode ? $past(pwdata[13:12]) : 2'h0))
        else $error("div");
    a_prio_map: assert property (
        wr |=> prio_req_high == (xbus_mode ? 4'h0 : $past(pwdata[3:0])))
        else $error("prio");
    a_no_tick: assert property (
        !xbus_mode && !$past(xbus_mode) |-> !strobe_tick) else $error("tick");
    a_mode_bit: assert property (
        rd |-> prdata[23] == !xbus_mode) else $error("mode bit");
    a_zero_bits: assert property (
        rd |-> prdata[22:14] == 9'h0) else $error("zero bits");
    a_read_back: assert property (
        s_back |-> (prdata & XCA_RW_MASK) == ($past(pwdata, 3) & XCA_RW_MASK))
        else $error("readback");
endmodule // xca_cfg_chk
bind xca_cfg xca_cfg_chk chk_u (.*);
`default_nettype wire

// *** tb/tb_xca_cfg.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_xca_cfg;
    import xca_pkg::*;
    logic sys_clk, sys_rst, mode_strap_pin, psel, penable, pwrite, err;
    logic clk_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, w;
    wire logic pready, pslverr, xbus_mode, strobe_tick, pci_irq_active_high;
    wire logic prio_self_high;
    wire logic [31:0] prdata;
    wire logic [2:0] cyc_len_cs0, cs_active_high;
    wire logic [1:0] strobe_div_sel;
    wire logic [3:0] irq_in_active_high, prio_req_high;
    int mismatches, compares, n;
    xca_cfg dut_u (.*, .cyc_len_cs1(), .cyc_len_cs2(),
        .cyc_len_none());
    // ----
    // helpers
    // ----
    task automatic chk(input string s, input logic [31:0] g, e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge sys_clk);
    endtask
    function automatic logic [31:0] expv(input logic [31:0] d, input logic x);
        return (d & XCA_RW_MASK) | {8'h0, ~x, 23'h0};
    endfunction
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #200000;
        mismatches++;
        end_of_test;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        clk_en = 1'h1;
        void'($urandom(60));
        for (int m = 1; m >= 0; m--) begin
            mode_strap_pin <= m[0];
            sys_rst <= 1'h1;
            repeat (12) @(posedge sys_clk);
            sys_rst <= 1'h0;
            repeat (3) @(posedge sys_clk);
            apb(1'h0, XCA_CFG_ADDR, 32'h0);
            chk("reset", rd, expv(32'h0, m[0]));
            for (int i = 0; i < 10; i++) begin
                w = i == 0 ? 32'hffff_ffff : i == 1 ? 32'h0 : $urandom;
                apb(1'h1, XCA_CFG_ADDR, w);
                apb(1'h0, XCA_CFG_ADDR, 32'h0);
                chk("rdback", rd, expv(w, m[0]));
                chk("levels", {pci_irq_active_high, cs_active_high,
                    irq_in_active_high}, w[31:24]);
                chk("cyc", cyc_len_cs0, m[0] ? w[2:0] : 3'h0);
                chk("prio", {prio_self_high, prio_req_high},
                    m[0] ? 5'h0 : w[4:0]);
            end
            apb(1'h1, 12'h14c, 32'h0);
            chk("err", err, 1'h1);
            apb(1'h0, 12'h14c, 32'h0);
            chk("unmapped", rd, 32'h0);
            for (int s = 0; s < 4; s++) begin
                apb(1'h1, XCA_CFG_ADDR, {18'h0, s[1:0], 12'h0});
                chk("div", strobe_div_sel, m[0] ? s[1:0] : 2'h0);
                repeat (4) @(posedge sys_clk);
                n = 0;
                repeat (12) begin
                    @(negedge sys_clk);
                    n += strobe_tick;
                end
                chk("ticks", n, m[0] ? 12 / (s + 1) : 0);
            end
            // frozen clock: a write must not land
            clk_en <= 1'h0;
            apb(1'h1, XCA_CFG_ADDR, 32'h5a5a_5a5a);
            clk_en <= 1'h1;
            apb(1'h0, XCA_CFG_ADDR, 32'h0);
            chk("frozen", rd, expv(32'h0000_3000, m[0]));
            $display("mode %0d test done", m);
        end
        end_of_test;
    end
endmodule // tb_xca_cfg
`default_nettype wire
